/* design/mau_top.sv */
//Contract
//RULE1: Large program memory pages via status bits
//RULE2: Large register files banked by pointer bits
//RULE3: Counter width 9, 10 or 11 bits
//RULE4: Out-of-range program addresses wrap around
//RULE5: Reset vector is last program location
//RULE6: Counter wraps from reset vector to 000h
//RULE7: Window has no storage, redirects via pointer
//RULE8: Window read of itself returns 00h
//RULE9: Window write to itself changes nothing
//RULE10: Pointer is 5 or 7 bits wide
//RULE11: Pointer low bits address 00h to 1Fh
//RULE12: Unbanked pointer bits 6:5 read ones
//RULE13: Banked pointer bits 6:5 select bank
//RULE14: Jump loads immediate plus page bits
//RULE15: Sequential fetch advances counter by one
`timescale 1ns/1ps
`include "mau_consts.svh"

module mau_top
   import mau_pkg::*;
#(
   parameter int PC_W = 9,
   parameter bit BANKED = 1'b0
) (
   input wire logic clk_in,
   input wire logic resetn_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [11:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   output logic [PC_W-1:0] pc_out
);
   // Data memory depth follows the banking option
   localparam int MEM_AW = BANKED ? `MAU_PTR_W : `MAU_PTR_LO_W; // RULE2 RULE10
   localparam logic [PC_W-1:0] RST_VEC = '1; // RULE5
   localparam logic [PC_W-1:0] PC_ONE = PC_W'(1);

   logic [`MAU_PTR_W-1:0] ptr;
   logic [`MAU_PTR_W-1:0] next_ptr;
   logic [1:0] page;
   logic [1:0] next_page;
   logic [PC_W-1:0] pc;
   logic [PC_W-1:0] next_pc;
   logic [31:0] next_prdata;
   logic next_pready;
   logic next_pslverr;
   mau_reg_t reg_sel;
   logic setup;
   logic first_access;
   logic done;
   logic self_ptr;
   logic mem_we;
   logic [MEM_AW-1:0] mem_addr;
   logic [`MAU_DATA_W-1:0] mem_rdata;
   logic [`MAU_PC_MAX_W-1:0] jump_target;

   // Address decode; unaligned or unknown offsets select nothing
   always_comb begin
      case (paddr_in)
         `MAU_OFF_PTR: reg_sel = MAU_REG_PTR;
         `MAU_OFF_WIN: reg_sel = MAU_REG_WIN;
         `MAU_OFF_PAGE: reg_sel = MAU_REG_PAGE;
         `MAU_OFF_PC: reg_sel = MAU_REG_PC;
         `MAU_OFF_STEP: reg_sel = MAU_REG_STEP;
         `MAU_OFF_JUMP: reg_sel = MAU_REG_JUMP;
         default: reg_sel = MAU_REG_NONE;
      endcase
   end

   // Bus phases
   assign setup = psel_in && !penable_in;
   assign first_access = psel_in && penable_in && !pready_out;
   assign done = psel_in && penable_in && pready_out;

   // Window target: pointer low bits, plus bank bits when banked
   assign mem_addr = ptr[MEM_AW-1:0]; // RULE7 RULE11 RULE13
   assign self_ptr = (ptr[`MAU_PTR_LO_W-1:0] == `MAU_SELF_ADDR); // RULE8
   // Write through the window only lands when it does not point to itself
   assign mem_we = done && pwrite_in && (reg_sel == MAU_REG_WIN) && !self_ptr; // RULE9 RULE7

   // Jump target: page bits above the 9-bit immediate
   assign jump_target = {page, pwdata_in[`MAU_JUMP_IMM_W-1:0]}; // RULE14 RULE1

   // Window storage lives only in the data memory
   mau_data_mem #(
      .AW(MEM_AW),
      .DW(`MAU_DATA_W)
   ) u_mem (
      .clk_in(clk_in),
      .resetn_in(resetn_in),
      .we_in(mem_we),
      .waddr_in(mem_addr),
      .wdata_in(pwdata_in[`MAU_DATA_W-1:0]),
      .raddr_in(mem_addr),
      .rdata_out(mem_rdata)
   );

   // Pointer and page register next values
   always_comb begin
      next_ptr = ptr;
      next_page = page;
      if (done && pwrite_in && reg_sel == MAU_REG_PTR) begin
         next_ptr[`MAU_PTR_LO_W-1:0] = pwdata_in[`MAU_PTR_LO_W-1:0]; // RULE11
         if (BANKED) begin
            next_ptr[`MAU_PTR_BANK_HI:`MAU_PTR_BANK_LO] =
               pwdata_in[`MAU_PTR_BANK_HI:`MAU_PTR_BANK_LO]; // RULE13
         end
      end
      // Unimplemented bank bits stay at ones whatever is written
      if (!BANKED) begin
         next_ptr[`MAU_PTR_BANK_HI:`MAU_PTR_BANK_LO] = `MAU_BANK_UNIMPL; // RULE12
      end
      if (done && pwrite_in && reg_sel == MAU_REG_PAGE) begin
         next_page = pwdata_in[`MAU_PAGE_HI:`MAU_PAGE_LO]; // RULE1
      end
   end

   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         ptr <= {(BANKED ? `MAU_BANK_RST : `MAU_BANK_UNIMPL), `MAU_PTR_LO_RST};
         page <= `MAU_PAGE_RST;
      end else begin
         ptr <= next_ptr;
         page <= next_page;
      end
   end

   // Program counter: step wraps modulo width, jump truncates to width
   always_comb begin
      next_pc = pc;
      if (done && pwrite_in && reg_sel == MAU_REG_STEP) begin
         next_pc = pc + PC_ONE; // RULE15 RULE4 RULE6
      end else if (done && pwrite_in && reg_sel == MAU_REG_JUMP) begin
         // Bits above the counter width are dropped, so high targets wrap
         next_pc = jump_target[PC_W-1:0]; // RULE14 RULE4 RULE3
      end
   end

   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         pc <= RST_VEC; // RULE5
      end else begin
         pc <= next_pc;
      end
   end

   assign pc_out = pc;

   // Bus answer: one wait state so memory read data is ready
   always_comb begin
      next_pready = first_access;
      next_pslverr = first_access && (reg_sel == MAU_REG_NONE);
      next_prdata = prdata_out;
      if (first_access) begin
         next_prdata = '0;
         case (reg_sel)
            MAU_REG_PTR: next_prdata[`MAU_PTR_W-1:0] = ptr; // RULE12
            MAU_REG_WIN: begin
               if (self_ptr) begin
                  next_prdata[`MAU_DATA_W-1:0] = `MAU_SELF_READ; // RULE8
               end else begin
                  next_prdata[`MAU_DATA_W-1:0] = mem_rdata; // RULE7
               end
            end
            MAU_REG_PAGE: next_prdata[`MAU_PAGE_HI:`MAU_PAGE_LO] = page;
            MAU_REG_PC: next_prdata[PC_W-1:0] = pc;
            default: next_prdata = '0;
         endcase
      end
   end

   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         pready_out <= 1'b0;
         pslverr_out <= 1'b0;
         prdata_out <= '0;
      end else begin
         pready_out <= next_pready;
         pslverr_out <= next_pslverr;
         prdata_out <= next_prdata;
      end
   end

   // Checks
   logic past_valid;
   always_ff @(posedge clk_in) begin
      past_valid <= resetn_in;
   end

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!resetn_in);

   sequence s_step_done;
      done && pwrite_in && reg_sel == MAU_REG_STEP;
   endsequence

   sequence s_setup_wait;
      setup ##1 (penable_in && !pready_out);
   endsequence

   // Completed register commands, each but s_jump_done the first step of a check below
   sequence s_jump_done;
      done && pwrite_in && reg_sel == MAU_REG_JUMP;
   endsequence

   sequence s_ptr_wr_done;
      done && pwrite_in && reg_sel == MAU_REG_PTR;
   endsequence

   sequence s_page_wr_done;
      done && pwrite_in && reg_sel == MAU_REG_PAGE;
   endsequence

   // Self-pointing window accesses are left out; they never touch memory
   sequence s_win_wr_done;
      done && pwrite_in && reg_sel == MAU_REG_WIN && !self_ptr;
   endsequence

   sequence s_win_rd_done;
      done && !pwrite_in && reg_sel == MAU_REG_WIN && !self_ptr;
   endsequence

   sequence s_ptr_rd_done;
      done && !pwrite_in && reg_sel == MAU_REG_PTR;
   endsequence

   property p_step_adds_one;
      s_step_done |=> pc == $past(pc) + PC_ONE;
   endproperty
   a_step_adds_one: assert property (p_step_adds_one) // RULE15
      else $error("step did not advance counter by one");

   property p_vector_wraps;
      (s_step_done ##0 (pc == RST_VEC)) |=> pc == '0;
   endproperty
   a_vector_wraps: assert property (p_vector_wraps) // RULE6
      else $error("step at reset vector did not wrap to zero");

   property p_reset_vector;
      (past_valid == 1'b0) |-> pc == RST_VEC;
   endproperty
   a_reset_vector: assert property (p_reset_vector) // RULE5
      else $error("counter not at reset vector after reset");

   property p_jump_load;
      (done && pwrite_in && reg_sel == MAU_REG_JUMP) |=>
         pc == $past(jump_target[PC_W-1:0]);
   endproperty
   a_jump_load: assert property (p_jump_load) // RULE14
      else $error("jump did not load immediate with page bits");

   property p_self_read_zero;
      (done && !pwrite_in && reg_sel == MAU_REG_WIN && self_ptr) |->
         prdata_out == 32'h0000_0000;
   endproperty
   a_self_read_zero: assert property (p_self_read_zero) // RULE8
      else $error("window read of itself not zero");

   property p_self_write_nop;
      (psel_in && penable_in && self_ptr) |-> !mem_we;
   endproperty
   a_self_write_nop: assert property (p_self_write_nop) // RULE9
      else $error("window write to itself reached memory");

   property p_unbanked_ones;
      !BANKED |-> ptr[`MAU_PTR_BANK_HI:`MAU_PTR_BANK_LO] == `MAU_BANK_UNIMPL;
   endproperty
   a_unbanked_ones: assert property (p_unbanked_ones) // RULE12
      else $error("unbanked pointer high bits not ones");

   property p_bank_write;
      (BANKED && done && pwrite_in && reg_sel == MAU_REG_PTR) |=>
         ptr == $past(pwdata_in[`MAU_PTR_W-1:0]);
   endproperty
   a_bank_write: assert property (p_bank_write) // RULE13
      else $error("banked pointer did not take written bank bits");

   property p_answer_timing;
      s_setup_wait |=> pready_out;
   endproperty
   a_answer_timing: assert property (p_answer_timing)
      else $error("bus answer not on second access cycle");

   property p_pc_stable;
      !(done && pwrite_in && (reg_sel == MAU_REG_STEP || reg_sel == MAU_REG_JUMP))
         |=> $stable(pc);
   endproperty
   a_pc_stable: assert property (p_pc_stable) // RULE4
      else $error("counter changed without step or jump");

   property p_ptr_low_write;
      s_ptr_wr_done |=> ptr[`MAU_PTR_LO_W-1:0] == $past(pwdata_in[`MAU_PTR_LO_W-1:0]);
   endproperty
   a_ptr_low_write: assert property (p_ptr_low_write) // RULE11
      else $error("pointer low bits did not take written value");

   property p_page_write;
      s_page_wr_done |=> page == $past(pwdata_in[`MAU_PAGE_HI:`MAU_PAGE_LO]);
   endproperty
   a_page_write: assert property (p_page_write) // RULE1
      else $error("page bits did not take written value");

   // Read port lags a write by one edge, so the new word shows two edges on
   property p_win_write_lands;
      s_win_wr_done |-> ##2 mem_rdata == $past(pwdata_in[`MAU_DATA_W-1:0], 2);
   endproperty
   a_win_write_lands: assert property (p_win_write_lands) // RULE7 RULE2
      else $error("window write did not reach the pointed register");

   property p_win_read_data;
      s_win_rd_done |-> prdata_out == 32'($past(mem_rdata));
   endproperty
   a_win_read_data: assert property (p_win_read_data) // RULE7
      else $error("window read did not return the pointed register");

   property p_ptr_read;
      s_ptr_rd_done |-> prdata_out == 32'($past(ptr));
   endproperty
   a_ptr_read: assert property (p_ptr_read) // RULE10 RULE12
      else $error("pointer read did not return the pointer");

   property p_unmapped_err;
      (done && reg_sel == MAU_REG_NONE) |-> pslverr_out && prdata_out == 32'h0000_0000;
   endproperty
   a_unmapped_err: assert property (p_unmapped_err)
      else $error("unmapped access not refused");

   property p_mapped_ok;
      (done && reg_sel != MAU_REG_NONE) |-> !pslverr_out;
   endproperty
   a_mapped_ok: assert property (p_mapped_ok)
      else $error("mapped access flagged as error");

   // Ready is a single-cycle answer, never held
   property p_ready_pulse;
      pready_out |=> !pready_out;
   endproperty
   a_ready_pulse: assert property (p_ready_pulse)
      else $error("ready stood longer than one cycle");

   property p_reset_bus;
      (past_valid == 1'b0) |-> !pready_out && !pslverr_out && prdata_out == 32'h0000_0000;
   endproperty
   a_reset_bus: assert property (p_reset_bus)
      else $error("bus outputs not idle after reset");
endmodule

/* common/mau_consts.svh */
`ifndef MAU_CONSTS_SVH
`define MAU_CONSTS_SVH

// APB register byte offsets
`define MAU_OFF_PTR 12'h000
`define MAU_OFF_WIN 12'h004
`define MAU_OFF_PAGE 12'h008
`define MAU_OFF_PC 12'h00C
`define MAU_OFF_STEP 12'h010
`define MAU_OFF_JUMP 12'h014

// Field positions and widths
`define MAU_PTR_W 7
`define MAU_PTR_LO_W 5
`define MAU_PTR_BANK_HI 6
`define MAU_PTR_BANK_LO 5
`define MAU_PAGE_HI 6
`define MAU_PAGE_LO 5
`define MAU_JUMP_IMM_W 9
`define MAU_DATA_W 8
`define MAU_PC_MAX_W 11

// Reset and fixed values
`define MAU_PTR_LO_RST 5'h00
`define MAU_BANK_RST 2'h0
`define MAU_BANK_UNIMPL 2'h3
`define MAU_PAGE_RST 2'h0
`define MAU_SELF_ADDR 5'h00
`define MAU_SELF_READ 8'h00

`endif

/* common/mau_pkg.sv */
package mau_pkg;
   // Decoded register select
   typedef enum logic [2:0] {
      MAU_REG_PTR = 3'b000,
      MAU_REG_WIN = 3'b001,
      MAU_REG_PAGE = 3'b010,
      MAU_REG_PC = 3'b011,
      MAU_REG_STEP = 3'b100,
      MAU_REG_JUMP = 3'b101,
      MAU_REG_NONE = 3'b111
   } mau_reg_t;
endpackage

/* design/mau_data_mem.sv */
`timescale 1ns/1ps
`include "mau_consts.svh"

module mau_data_mem
   import mau_pkg::*;
#(
   parameter int AW = 5,
   parameter int DW = `MAU_DATA_W
) (
   input wire logic clk_in,
   input wire logic resetn_in,
   input wire logic we_in,
   input wire logic [AW-1:0] waddr_in,
   input wire logic [DW-1:0] wdata_in,
   input wire logic [AW-1:0] raddr_in,
   output logic [DW-1:0] rdata_out
);
   logic [DW-1:0] mem [0:(1<<AW)-1];
   logic [DW-1:0] next_rdata;

   // Registered read port, no reset on the array itself
   always_comb begin
      next_rdata = mem[raddr_in];
   end

   always_ff @(posedge clk_in) begin
      if (we_in) begin
         mem[waddr_in] <= wdata_in;
      end
      if (!resetn_in) begin
         rdata_out <= '0;
      end else begin
         rdata_out <= next_rdata;
      end
   end
endmodule

/* dv/mau_core_model.sv */
`timescale 1ns/1ps

module mau_core_model (
   input wire logic clk_in,
   input wire logic pready_in,
   input wire logic pslverr_in,
   input wire logic [31:0] prdata_in,
   output logic psel_out,
   output logic penable_out,
   output logic pwrite_out,
   output logic [11:0] paddr_out,
   output logic [31:0] pwdata_out
);
   // Idle bus at time zero
   initial begin
      psel_out <= 1'b0;
      penable_out <= 1'b0;
      pwrite_out <= 1'b0;
      paddr_out <= 12'h000;
      pwdata_out <= 32'h0;
   end

   // One transfer: setup cycle, then access until ready is seen at a rising edge
   // No cycle limit here; the bench timeout ends a hung wait
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] r, output logic e);
      @(posedge clk_in);
      psel_out <= 1'b1;
      penable_out <= 1'b0;
      pwrite_out <= w;
      paddr_out <= a;
      pwdata_out <= d;
      @(posedge clk_in);
      penable_out <= 1'b1;
      do begin
         @(posedge clk_in);
      end while (pready_in !== 1'b1);
      // Answer taken at the same edge that sees ready, then released
      r = prdata_in;
      e = pslverr_in;
      psel_out <= 1'b0;
      penable_out <= 1'b0;
   endtask
endmodule

/* dv/mau_top_bench.sv */
`timescale 1ns/1ps
`include "mau_consts.svh"

module mau_top_bench;
   localparam int PW = 10;
   logic clk_in;
   logic resetn_in;
   logic psel, penable, pwrite, pready, pslverr, er;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [PW-1:0] pc, epc;
   logic [7:0] mem [0:127];
   logic [6:0] plist [0:7];
   int n_errors, checks_done, cyc;
   localparam int PWS = 9;
   logic psel_s, penable_s, pwrite_s, pready_s, pslverr_s;
   logic [11:0] paddr_s;
   logic [31:0] pwdata_s, prdata_s;
   logic [PWS-1:0] pc_s;

   mau_top #(.PC_W(PW), .BANKED(1'b1)) dut (.clk_in(clk_in), .resetn_in(resetn_in),
      .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
      .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
      .pslverr_out(pslverr), .pc_out(pc));

   mau_core_model core (.clk_in(clk_in), .pready_in(pready), .pslverr_in(pslverr),
      .prdata_in(prdata), .psel_out(psel), .penable_out(penable),
      .pwrite_out(pwrite), .paddr_out(paddr), .pwdata_out(pwdata));

   // Second build: unbanked pointer, 512-word program space
   mau_top #(.PC_W(PWS), .BANKED(1'b0)) dut_small (.clk_in(clk_in), .resetn_in(resetn_in),
      .psel_in(psel_s), .penable_in(penable_s), .pwrite_in(pwrite_s), .paddr_in(paddr_s),
      .pwdata_in(pwdata_s), .prdata_out(prdata_s), .pready_out(pready_s),
      .pslverr_out(pslverr_s), .pc_out(pc_s));

   mau_core_model core_small (.clk_in(clk_in), .pready_in(pready_s), .pslverr_in(pslverr_s),
      .prdata_in(prdata_s), .psel_out(psel_s), .penable_out(penable_s),
      .pwrite_out(pwrite_s), .paddr_out(paddr_s), .pwdata_out(pwdata_s));

   // Free-running clock
   initial begin
      clk_in = 1'b0;
      forever #20 clk_in = ~clk_in;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      core.xfer(1'b1, a, d, rd, er);
      chk({31'h0, er}, 32'h0);
   endtask

   task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
      core.xfer(1'b0, a, 32'h0, rd, er);
      chk(rd, exp);
   endtask

   // Counter is registered, so look at it mid-cycle after the command
   task automatic cpc(input logic [PW-1:0] exp);
      @(negedge clk_in);
      chk(32'(pc), 32'(exp));
   endtask

   task automatic cps(input logic [31:0] exp);
      @(negedge clk_in);
      chk(32'(pc_s), exp);
   endtask

   task automatic wrs(input logic [11:0] a, input logic [31:0] d);
      core_small.xfer(1'b1, a, d, rd, er);
      chk({31'h0, er}, 32'h0);
   endtask

   task automatic rds(input logic [11:0] a, input logic [31:0] exp);
      core_small.xfer(1'b0, a, 32'h0, rd, er);
      chk(rd, exp);
   endtask

   // Last program location for a counter of w bits
   function automatic logic [31:0] vec_of(input int w);
      return (32'h1 << w) - 32'h1;
   endfunction

   // Jump target: page above immediate, cut to the counter width
   function automatic logic [31:0] jump_of(input int w, input logic [1:0] pg,
      input logic [8:0] imm);
      return {21'h0, pg, imm} & vec_of(w);
   endfunction

   task automatic summarize;
      $display("checks=%0d errors=%0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // Hang guard, well above the few hundred cycles the tests need
   always @(posedge clk_in) begin
      cyc++;
      if (cyc == 5000) begin
         n_errors++;
         summarize();
      end
   end

   initial begin
      int s, k, p;
      logic [6:0] ptr;
      n_errors = 0;
      checks_done = 0;
      cyc = 0;
      resetn_in = 1'b0;
      s = $urandom(56);
      repeat (4) @(posedge clk_in);
      resetn_in <= 1'b1;
      @(negedge clk_in);
      chk(32'(pc), vec_of(PW));
      chk(32'(pc_s), vec_of(PWS));
      wr(`MAU_OFF_STEP, 32'h0);
      cpc(0);
      k = $urandom_range(3, 12);
      epc = 0;
      repeat (k) begin
         wr(`MAU_OFF_STEP, $urandom());
         epc++;
      end
      cpc(epc);
      $display("test step done");
      // Every page value, random immediate
      for (p = 0; p < 4; p++) begin
         k = $urandom_range(0, 511);
         wr(`MAU_OFF_PAGE, 32'(p << 5));
         wr(`MAU_OFF_JUMP, 32'(k));
         cpc(PW'(jump_of(PW, p[1:0], k[8:0])));
      end
      wr(`MAU_OFF_JUMP, 32'h1FF);
      wr(`MAU_OFF_STEP, 32'h0);
      cpc(0);
      wr(`MAU_OFF_PC, 32'h55);
      rdc(`MAU_OFF_PC, 32'h0);
      $display("test jump done");
      // Same offset in two banks first, then random pointers
      for (k = 0; k < 8; k++) begin
         ptr = (k == 0) ? 7'h25 : (k == 1) ? 7'h65 : 7'($urandom());
         if (ptr[4:0] == 5'h00) ptr[0] = 1'b1;
         plist[k] = ptr;
         wr(`MAU_OFF_PTR, {25'h0, ptr});
         rdc(`MAU_OFF_PTR, {25'h0, ptr});
         mem[ptr] = (k < 2) ? 8'(8'hA0 + k) : 8'($urandom());
         wr(`MAU_OFF_WIN, {24'h0, mem[ptr]});
      end
      wr(`MAU_OFF_PTR, 32'h40);
      rdc(`MAU_OFF_WIN, 32'h0);
      wr(`MAU_OFF_WIN, 32'hFF);
      rdc(`MAU_OFF_WIN, 32'h0);
      // Reread every target after the self write; none of them is the self-pointing location 40h
      for (k = 0; k < 8; k++) begin
         wr(`MAU_OFF_PTR, {25'h0, plist[k]});
         rdc(`MAU_OFF_WIN, {24'h0, mem[plist[k]]});
      end
      $display("test window done");
      // Unbanked build: bank bits stay ones, page bits fall off a 9-bit counter
      wrs(`MAU_OFF_PTR, 32'h0000_002A);
      rds(`MAU_OFF_PTR, 32'h0000_006A);
      wrs(`MAU_OFF_WIN, 32'h0000_005C);
      wrs(`MAU_OFF_PTR, 32'h0000_000A);
      rds(`MAU_OFF_WIN, 32'h0000_005C);
      wrs(`MAU_OFF_PAGE, 32'h0000_0060);
      wrs(`MAU_OFF_JUMP, 32'h0000_00F0);
      cps(jump_of(PWS, 2'h3, 9'h0F0));
      wrs(`MAU_OFF_JUMP, 32'h0000_01FF);
      wrs(`MAU_OFF_STEP, 32'h0000_0000);
      cps(32'h0000_0000);
      $display("test unbanked done");
      // Reset again mid-run: counters back at the last location
      @(posedge clk_in);
      resetn_in <= 1'b0;
      repeat (2) @(posedge clk_in);
      resetn_in <= 1'b1;
      cpc(PW'(vec_of(PW)));
      cps(vec_of(PWS));
      rdc(`MAU_OFF_PTR, 32'h0000_0000);
      rds(`MAU_OFF_PTR, 32'h0000_0060);
      $display("test reset done");
      core.xfer(1'b0, 12'h020, 32'h0, rd, er);
      chk({31'h0, er}, 32'h1);
      chk(rd, 32'h0);
      $display("test unmapped done");
      summarize();
   end
endmodule
